//--- src/cond_move_compare_decode.sv
// Decoder and clock-count sequencer for conditional moves and compares
`timescale 1ns/10ps
`include "cmc_defines.svh"
// How it works
// - 0F 41 moves when overflow clear
// - 0F 4A moves when parity set
// - 0F 4B moves when parity clear
// - 0F 48/49 move on sign match
// - Conditional moves take one clock
// - Compare register/memory forms, one clock, flags
// - Compare immediate forms, one clock, flags
// - Register compare-and-swap, six clocks, flags
// - Memory compare-and-swap, six clocks
// - 0F C7 reg 001, memory only
// - 0F B0/B1 swap accepts register and memory forms
module cond_move_compare_decode
  import cmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire flags_t i_flags,
  output logic o_byte_ready,
  output logic o_issue_valid,
  output decoded_t o_issue,
  output logic o_move_taken,
  output logic o_illegal,
  output logic o_busy
);
  typedef enum logic [3:0] {
    ST_OPCODE = 4'b0001,
    ST_ESCAPE = 4'b0010,
    ST_MODRM = 4'b0100,
    ST_EXEC = 4'b1000
  } state_t;

  state_t state_ff;
  decoded_t pend_ff;
  logic [3:0] count_ff;
  logic issue_valid_ff;
  decoded_t issue_ff;
  logic taken_ff;
  logic illegal_ff;
  logic ready_ff;
  logic busy_ff;
  logic take_cond;
  logic accept;
  decoded_t nxt_pend;
  logic nxt_need_modrm;
  logic nxt_bad;
  decoded_t with_modrm;
  logic modrm_bad;

  assign accept = i_byte_valid & ready_ff;

  cmc_cond_eval u_cond (
    .i_cond(with_modrm.cond),
    .i_flags(i_flags),
    .o_take(take_cond)
  );

  // Classify a one-byte opcode or a byte after the escape
  always_comb begin
    nxt_pend = '0;
    nxt_need_modrm = 1'b0;
    nxt_bad = 1'b0;
    nxt_pend.wide = i_byte[`BIT_WIDTH];
    if (state_ff == ST_OPCODE) begin
      if ((i_byte & `OPC_CMP_RM_MASK) == `OPC_CMP_RM) begin
        nxt_pend.kind = OP_COMPARE;
        nxt_pend.dir_to_reg = i_byte[`BIT_DIR];
        nxt_pend.writes_flags = 1'b1;
        nxt_pend.clocks = `CLK_SINGLE;
        nxt_need_modrm = 1'b1;
      end else if ((i_byte & `OPC_CMP_ACC_MASK) == `OPC_CMP_ACC) begin
        nxt_pend.kind = OP_COMPARE;
        nxt_pend.acc_form = 1'b1;
        nxt_pend.has_imm = 1'b1;
        nxt_pend.writes_flags = 1'b1;
        nxt_pend.clocks = `CLK_SINGLE;
      end else if ((i_byte & `OPC_CMP_IMM_MASK) == `OPC_CMP_IMM) begin
        nxt_pend.kind = OP_COMPARE;
        nxt_pend.has_imm = 1'b1;
        nxt_pend.sext_imm = i_byte[`BIT_SEXT];
        nxt_pend.writes_flags = 1'b1;
        nxt_pend.clocks = `CLK_SINGLE;
        nxt_need_modrm = 1'b1;
      end else begin
        nxt_bad = (i_byte != `OPC_ESCAPE);
      end
    end else begin
      nxt_need_modrm = 1'b1;
      nxt_pend.wide = 1'b1;
      nxt_pend.kind = OP_MOVE_COND;
      nxt_pend.clocks = `CLK_SINGLE;
      if (i_byte == `OPC_MOV_NO) begin
        nxt_pend.cond = COND_NO_OVERFLOW;
      end else if (i_byte == `OPC_MOV_PE) begin
        nxt_pend.cond = COND_PARITY_SET;
      end else if (i_byte == `OPC_MOV_PO) begin
        nxt_pend.cond = COND_PARITY_CLEAR;
      end else if (i_byte == `OPC_MOV_SS) begin
        nxt_pend.cond = COND_SIGN_SET;
      end else if (i_byte == `OPC_MOV_SC) begin
        nxt_pend.cond = COND_SIGN_CLEAR;
      end else if ((i_byte & `OPC_CAS_MASK) == `OPC_CAS) begin
        nxt_pend.kind = OP_CAS;
        nxt_pend.wide = i_byte[`BIT_WIDTH];
        nxt_pend.writes_flags = 1'b1;
        nxt_pend.clocks = `CLK_CAS;
      end else if (i_byte == `OPC_CAS8) begin
        nxt_pend.kind = OP_CAS8;
        nxt_pend.clocks = `CLK_SINGLE;
      end else begin
        nxt_pend.kind = OP_NONE;
        nxt_bad = 1'b1;
      end
    end
  end

  // Merge the mod/reg/rm byte into the pending decode
  always_comb begin
    with_modrm = pend_ff;
    modrm_bad = 1'b0;
    with_modrm.reg_field = i_byte[5:3];
    with_modrm.rm_field = i_byte[2:0];
    with_modrm.mem_operand = (i_byte[7:6] != `MOD_REGISTER);
    if (pend_ff.kind == OP_COMPARE && pend_ff.has_imm) begin
      modrm_bad = (i_byte[5:3] != `REG_CMP_IMM);
    end
    if (pend_ff.kind == OP_CAS8) begin
      // Register form has no meaning for an eight-byte swap
      modrm_bad = (i_byte[5:3] != `REG_CAS8) |
                  (i_byte[7:6] == `MOD_REGISTER);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= ST_OPCODE;
      pend_ff <= '0;
      count_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_OPCODE: begin
          if (accept && !nxt_bad) begin
            if (i_byte == `OPC_ESCAPE) begin
              state_ff <= ST_ESCAPE;
            end else if (nxt_need_modrm) begin
              pend_ff <= nxt_pend;
              state_ff <= ST_MODRM;
            end else begin
              pend_ff <= nxt_pend;
              count_ff <= nxt_pend.clocks - 4'h1;
              state_ff <= (nxt_pend.clocks > `CLK_SINGLE) ? ST_EXEC : ST_OPCODE;
            end
          end
        end
        ST_ESCAPE: begin
          if (accept) begin
            pend_ff <= nxt_pend;
            state_ff <= nxt_bad ? ST_OPCODE : ST_MODRM;
          end
        end
        ST_MODRM: begin
          if (accept) begin
            pend_ff <= with_modrm;
            count_ff <= pend_ff.clocks - 4'h1;
            // Multi-clock forms hold the front end for the remaining clocks
            if (!modrm_bad && pend_ff.clocks > `CLK_SINGLE) begin
              state_ff <= ST_EXEC;
            end else begin
              state_ff <= ST_OPCODE;
            end
          end
        end
        ST_EXEC: begin
          count_ff <= count_ff - 4'h1;
          if (count_ff == 4'h1) begin
            state_ff <= ST_OPCODE;
          end
        end
        default: state_ff <= ST_OPCODE;
      endcase
    end
  end

  // Issue one-clock results at once; multi-clock ones at the first clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      issue_valid_ff <= 1'b0;
      issue_ff <= '0;
      taken_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      issue_valid_ff <= 1'b0;
      taken_ff <= 1'b0;
      illegal_ff <= 1'b0;
      if (accept && state_ff == ST_OPCODE && !nxt_need_modrm && !nxt_bad &&
          i_byte != `OPC_ESCAPE) begin
        issue_valid_ff <= 1'b1;
        issue_ff <= nxt_pend;
      end else if (accept && state_ff == ST_MODRM) begin
        issue_valid_ff <= ~modrm_bad;
        illegal_ff <= modrm_bad;
        issue_ff <= with_modrm;
        // Moves never touch flags, taken or not
        taken_ff <= (pend_ff.kind == OP_MOVE_COND) & take_cond & ~modrm_bad;
      end else if (accept && nxt_bad && state_ff != ST_MODRM) begin
        illegal_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (state_ff != ST_EXEC) & ~(accept & state_ff == ST_MODRM &
                  ~modrm_bad & pend_ff.clocks > `CLK_SINGLE) &
                  ~(state_ff == ST_EXEC & count_ff != 4'h1);
      if (state_ff == ST_EXEC && count_ff == 4'h1) begin
        ready_ff <= 1'b1;
      end
    end
  end

  // Busy tracks the hold-off so the output comes from a flop, not a state decode
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_ff <= 1'b0;
    end else if (accept && state_ff == ST_MODRM && !modrm_bad &&
                 pend_ff.clocks > `CLK_SINGLE) begin
      busy_ff <= 1'b1;
    end else if (state_ff == ST_EXEC && count_ff == 4'h1) begin
      busy_ff <= 1'b0;
    end
  end

  assign o_byte_ready = ready_ff;
  assign o_issue_valid = issue_valid_ff;
  assign o_issue = issue_ff;
  assign o_move_taken = taken_ff;
  assign o_illegal = illegal_ff;
  assign o_busy = busy_ff;
endmodule

//--- inc/cmc_defines.svh
// Opcode encodings, field positions and clock counts for the compare/move decoder
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH
`define OPC_ESCAPE 8'h0F
`define OPC_MOV_NO 8'h41
`define OPC_MOV_PE 8'h4A
`define OPC_MOV_PO 8'h4B
`define OPC_MOV_SS 8'h48
`define OPC_MOV_SC 8'h49
`define OPC_CMP_RM_MASK 8'hFC
`define OPC_CMP_RM 8'h38
`define OPC_CMP_ACC_MASK 8'hFE
`define OPC_CMP_ACC 8'h3C
`define OPC_CMP_IMM_MASK 8'hFC
`define OPC_CMP_IMM 8'h80
`define OPC_CAS_MASK 8'hFE
`define OPC_CAS 8'hB0
`define OPC_CAS8 8'hC7
`define REG_CMP_IMM 3'h7
`define REG_CAS8 3'h1
`define MOD_REGISTER 2'h3
`define BIT_WIDTH 0
`define BIT_DIR 1
`define BIT_SEXT 1
`define CLK_SINGLE 4'h1
`define CLK_CAS 4'h6
`endif

//--- inc/cmc_pkg.sv
// Types shared by the compare/move decoder files
package cmc_pkg;
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_MOVE_COND = 5'h01,
    OP_COMPARE = 5'h02,
    OP_CAS = 5'h03,
    OP_CAS8 = 5'h04
  } op_kind_t;
  typedef enum logic [2:0] {
    COND_NO_OVERFLOW = 3'h0,
    COND_PARITY_SET = 3'h1,
    COND_PARITY_CLEAR = 3'h2,
    COND_SIGN_SET = 3'h3,
    COND_SIGN_CLEAR = 3'h4
  } cond_t;
  typedef struct packed {
    op_kind_t kind;
    cond_t cond;
    logic wide;
    logic dir_to_reg;
    logic sext_imm;
    logic has_imm;
    logic acc_form;
    logic mem_operand;
    logic writes_flags;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic [3:0] clocks;
  } decoded_t;
  typedef struct packed {
    logic overflow;
    logic sign;
    logic parity;
  } flags_t;
endpackage

//--- src/cmc_cond_eval.sv
// Condition evaluator for flag-conditional moves
`timescale 1ns/10ps
`include "cmc_defines.svh"
module cmc_cond_eval
  import cmc_pkg::*;
(
  input wire cond_t i_cond,
  input wire flags_t i_flags,
  output logic o_take
);
  always_comb begin
    o_take = 1'b0;
    case (i_cond)
      COND_NO_OVERFLOW: o_take = ~i_flags.overflow;
      COND_PARITY_SET: o_take = i_flags.parity;
      COND_PARITY_CLEAR: o_take = ~i_flags.parity;
      COND_SIGN_SET: o_take = i_flags.sign;
      COND_SIGN_CLEAR: o_take = ~i_flags.sign;
      default: o_take = 1'b0;
    endcase
  end
endmodule

//--- test/cmc_assertions.sv
// Port checker for the compare/move decoder
`timescale 1ns/10ps
module cmc_checker
  import cmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire flags_t i_flags,
  input wire logic o_byte_ready,
  input wire logic o_issue_valid,
  input wire decoded_t o_issue,
  input wire logic o_move_taken,
  input wire logic o_illegal,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic mv;
  assign mv = o_issue_valid && o_issue.kind == OP_MOVE_COND;
  a_move_overflow: assert property (mv && o_issue.cond == COND_NO_OVERFLOW
    |-> o_move_taken == !$past(i_flags.overflow)) else $error("overflow move wrong");
  a_move_parity: assert property (
    mv && o_issue.cond inside {COND_PARITY_SET, COND_PARITY_CLEAR}
    |-> o_move_taken == ($past(i_flags.parity) == (o_issue.cond == COND_PARITY_SET)))
    else $error("parity move wrong");
  a_move_sign: assert property (
    mv && o_issue.cond inside {COND_SIGN_SET, COND_SIGN_CLEAR}
    |-> o_move_taken == ($past(i_flags.sign) == (o_issue.cond == COND_SIGN_SET)))
    else $error("sign move wrong");
  a_move_one_clock: assert property (mv
    |-> o_issue.clocks == 4'h1 && !o_issue.writes_flags ##1 o_byte_ready)
    else $error("move timing");
  a_compare_flags: assert property (o_issue_valid && o_issue.kind == OP_COMPARE
    |-> o_issue.writes_flags && o_issue.clocks == 4'h1 && !o_busy) else $error("compare wrong");
  a_swap_six_clocks: assert property (o_issue_valid && o_issue.kind == OP_CAS
    |-> (o_busy && !o_byte_ready)[*5] ##1 (o_byte_ready && !o_busy)) else $error("swap busy");
  a_swap_fields: assert property (o_issue_valid && o_issue.kind == OP_CAS
    |-> o_issue.clocks == 4'h6 && o_issue.writes_flags) else $error("swap fields");
  a_wide_swap_memory: assert property (o_issue_valid && o_issue.kind == OP_CAS8
    |-> o_issue.mem_operand && o_issue.reg_field == 3'h1) else $error("eight byte swap");
  a_taken_source: assert property (o_move_taken |-> mv) else $error("stray move taken");
  c_move_taken: cover property (mv && o_move_taken);
  c_swap_regs: cover property (o_issue_valid && o_issue.kind == OP_CAS && !o_issue.mem_operand);
  c_illegal: cover property (o_illegal);
endmodule
bind cond_move_compare_decode cmc_checker u_chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_flags(i_flags),
  .o_byte_ready(o_byte_ready), .o_issue_valid(o_issue_valid), .o_issue(o_issue),
  .o_move_taken(o_move_taken), .o_illegal(o_illegal), .o_busy(o_busy));

//--- test/tb.sv
// Random and corner-case bench for the compare/move decoder
`timescale 1ns/10ps
module tb;
  import cmc_pkg::*;
  logic i_core_clk, i_rst_b, i_byte_valid, o_byte_ready, o_issue_valid;
  logic o_move_taken, o_illegal, o_busy, taken, ew;
  logic [7:0] i_byte, m, op;
  logic [3:0] ec;
  flags_t i_flags, f;
  decoded_t o_issue;
  op_kind_t ek;
  int errors, compares, issues, illegals, r;
  logic [7:0] mv_op [5] = '{8'h41, 8'h4A, 8'h4B, 8'h48, 8'h49};
  cond_move_compare_decode dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_flags(i_flags),
    .o_byte_ready(o_byte_ready), .o_issue_valid(o_issue_valid), .o_issue(o_issue),
    .o_move_taken(o_move_taken), .o_illegal(o_illegal), .o_busy(o_busy));
  initial begin
    i_core_clk = 0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  // Sampled mid-cycle so pulses are seen whatever the process order
  always @(negedge i_core_clk) begin
    if (o_issue_valid === 1'b1) begin
      issues++;
      taken = o_move_taken;
    end
    if (o_illegal === 1'b1) illegals++;
  end
  function automatic logic want(int c, flags_t g);
    case (c)
      0: want = !g.overflow;
      1: want = g.parity;
      2: want = !g.parity;
      3: want = g.sign;
      default: want = !g.sign;
    endcase
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ready is a register, so its mid-cycle value is what the next edge sees
  task automatic send(logic [7:0] b);
    i_byte_valid <= 1'b1;
    i_byte <= b;
    do @(negedge i_core_clk); while (o_byte_ready !== 1'b1);
    @(posedge i_core_clk);
  endtask
  task automatic inst(logic [7:0] b0, b1, b2, int n, logic bad);
    int i0, l0;
    i0 = issues;
    l0 = illegals;
    send(b0);
    if (n > 1) send(b1);
    if (n > 2) send(b2);
    i_byte_valid <= 1'b0;
    repeat (8) @(negedge i_core_clk);
    @(posedge i_core_clk);
    check("issues", issues - i0, bad ? 0 : 1);
    check("illegals", illegals - l0, bad ? 1 : 0);
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    i_rst_b = 0;
    i_byte_valid = 0;
    i_byte = 8'h00;
    i_flags = '0;
    r = $urandom(94);
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    inst(8'h0F, 8'hC7, 8'hC8, 3, 1'b1);
    inst(8'h0F, 8'hC7, 8'h10, 3, 1'b1);
    inst(8'h80, 8'h28, 8'h00, 2, 1'b1);
    send(8'h3C);
    send(8'h3D);
    // Drop valid so the second compare is counted before the swap's snapshot
    i_byte_valid <= 1'b0;
    @(posedge i_core_clk);
    inst(8'h0F, 8'hB1, 8'hC1, 3, 1'b0);
    check("back to back", issues, 3);
    for (int k = 0; k < 80; k++) begin
      r = $urandom_range(0, 9);
      m = $urandom;
      op = $urandom;
      f = flags_t'(3'($urandom));
      i_flags <= f;
      ek = OP_COMPARE;
      ec = 4'h1;
      ew = 1'b1;
      if (r < 5) begin
        ek = OP_MOVE_COND;
        ew = 1'b0;
        inst(8'h0F, mv_op[r], m, 3, 1'b0);
        check("cond", o_issue.cond, r);
        check("taken", taken, want(r, f));
      end else if (r == 5) begin
        inst(8'h38 | op[1:0], m, 8'h00, 2, 1'b0);
        check("dir wide", {o_issue.dir_to_reg, o_issue.wide}, op[1:0]);
      end else if (r == 6) begin
        m[5:3] = 3'h7;
        inst(8'h80 | op[1:0], m, 8'h00, 2, 1'b0);
        check("imm", {o_issue.has_imm, o_issue.sext_imm}, {1'b1, op[1]});
      end else if (r == 7) begin
        inst(8'h3C | op[0], 8'h00, 8'h00, 1, 1'b0);
        check("acc", {o_issue.acc_form, o_issue.wide}, {1'b1, op[0]});
      end else if (r == 8) begin
        ek = OP_CAS;
        ec = 4'h6;
        inst(8'h0F, 8'hB0 | op[0], m, 3, 1'b0);
        check("swap wide", o_issue.wide, op[0]);
      end else begin
        ek = OP_CAS8;
        ec = 4'h1;
        ew = 1'b0;
        m[7:3] = {2'($urandom_range(0, 2)), 3'h1};
        inst(8'h0F, 8'hC7, m, 3, 1'b0);
      end
      check("kind clk flags", {o_issue.kind, o_issue.clocks, o_issue.writes_flags},
        {ek, ec, ew});
      if (r != 7) check("mem rm", {o_issue.mem_operand, o_issue.rm_field},
        {m[7:6] != 2'h3, m[2:0]});
    end
    end_of_test();
  end
endmodule
